// ---- common/dacr_pkg.sv ----
// Constants, timing figures and carrier types of the dual converter readout
//
// Overview of operation
// - Start falling edge puts both track/holds in hold and starts converting.
// - Busy rises on the first clock edge after that start fall.
// - Busy falls within 3.6 us; both results then sit in the latch.
// - Select low reads pair A one then two; high reads pair B.
// - A read is select low plus read strobe low, repeated twice.
// - A full two-result read completes within 100 ns.
// - Start level at conversion end picks sleep (low) or continuous (high).
// - In sleep mode the device sleeps once busy falls.
// - Start rising edge wakes; 2.5 us external, 5 ms internal reference.
// - After wake, hold at once if start low, else at next fall.
// - Results stay readable while asleep, same strobe sequence.
package dacr_pkg;

  localparam int RESULT_WIDTH = 12;
  localparam int FIFO_DEPTH   = 4;
  localparam int CNT_WIDTH    = 18;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int CONV_TIME_NS   = 3600;
  localparam int WAKE_EXT_NS    = 2500;
  localparam int WAKE_INT_MS    = 5;
  localparam int READ_TIME_NS   = 100;
  localparam int SETTLE_NS      = 300;
  localparam int SELECT_SETUP_NS = 400;

  // Longest times round down to whole cycles
  localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_EXT_CYCLES = WAKE_EXT_NS / CLK_PERIOD_NS;
  localparam int WAKE_INT_CYCLES = WAKE_INT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int READ_CYCLES     = READ_TIME_NS / CLK_PERIOD_NS;

  localparam logic [CNT_WIDTH-1:0] CNT_RESET = 18'h00000;
  localparam logic [CNT_WIDTH-1:0] CONV_LAST =
    CNT_WIDTH'(CONV_CYCLES - 1);
  localparam logic [CNT_WIDTH-1:0] WAKE_EXT_LAST =
    CNT_WIDTH'(WAKE_EXT_CYCLES - 1);

  localparam logic [1:0] LOAD_NONE  = 2'h0;
  localparam logic [1:0] LOAD_TWO   = 2'h2;
  localparam logic       MODE_CONTINUOUS = 1'b0;
  localparam logic       MODE_SLEEP      = 1'b1;

  typedef logic [RESULT_WIDTH-1:0] dacr_word_t;

  typedef struct packed {
    dacr_word_t inputOne;
    dacr_word_t inputTwo;
  } dacr_pair_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_SLEEP,
    ST_WAKE
  } dacr_state_t;

endpackage

// ---- core/dacr_readout.sv ----
// Conversion control, result latch, readout FIFO and parallel read port
`timescale 1ns/1ps

module dacr_fifo
#(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Flush
  input  wire logic             clear,
  // Fill side
  input  wire logic             inValid,
  output      logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output      logic             outValid,
  input  wire logic             outReady,
  output      logic [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    wrPtr_nxt;
  logic [PW-1:0]    rdPtr_r;
  logic [PW-1:0]    rdPtr_nxt;
  logic [CW-1:0]    count_r;
  logic [CW-1:0]    count_nxt;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count_r != CNT_FULL) && !clear;
  assign outValid = (count_r != '0) && !clear;
  assign outData  = mem[rdPtr_r];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_comb
  begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (clear)
    begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
    end
    else
    begin
      if (doPush)
        wrPtr_nxt = (wrPtr_r == PTR_LAST) ? '0 : wrPtr_r + PW'(1);
      if (doPop)
        rdPtr_nxt = (rdPtr_r == PTR_LAST) ? '0 : rdPtr_r + PW'(1);
      if (doPush && !doPop)
        count_nxt = count_r + CW'(1);
      else if (doPop && !doPush)
        count_nxt = count_r - CW'(1);
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage carries no reset; only entries counted valid are ever read
  always_ff @(posedge clock)
  begin
    if (doPush)
      mem[wrPtr_r] <= inData;
  end

endmodule

module dacr_readout
#(
  parameter int unsigned WakeIntCycles = dacr_pkg::WAKE_INT_CYCLES
)
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                resetn,
  // Conversion control
  input  wire logic                conversion_start_n,
  input  wire logic                pair_select,
  input  wire logic                internalReference,
  // Digitised front-end inputs
  input  wire dacr_pkg::dacr_pair_t pairA,
  input  wire dacr_pkg::dacr_pair_t pairB,
  // Parallel read port
  input  wire logic                chipSelectN,
  input  wire logic                readN,
  output      dacr_pkg::dacr_word_t dataOut,
  output      logic                dataOe,
  // Status
  output      logic                busy,
  output      logic                holdActive,
  output      logic                asleep,
  output      logic                sleepMode
);

  localparam logic [dacr_pkg::CNT_WIDTH-1:0] WAKE_INT_LAST =
    dacr_pkg::CNT_WIDTH'(WakeIntCycles - 1);

  dacr_pkg::dacr_state_t state_r;
  dacr_pkg::dacr_state_t state_nxt;
  logic [dacr_pkg::CNT_WIDTH-1:0] cnt_r;
  logic [dacr_pkg::CNT_WIDTH-1:0] cnt_nxt;
  logic                 startPrev_r;
  logic                 readPrev_r;
  logic                 mode_r;
  logic                 mode_nxt;
  dacr_pkg::dacr_pair_t sample_r;
  dacr_pkg::dacr_pair_t sample_nxt;
  dacr_pkg::dacr_pair_t latch_r;
  dacr_pkg::dacr_pair_t latch_nxt;
  logic [1:0]           loadLeft_r;
  logic [1:0]           loadLeft_nxt;
  dacr_pkg::dacr_word_t dataOut_r;
  dacr_pkg::dacr_word_t dataOut_nxt;

  logic                 startFall;
  logic                 startRise;
  logic                 readStart;
  logic                 readEnd;
  logic                 convDone;
  logic                 wakeDone;
  logic                 beginHold;
  logic                 fifoClear;
  logic                 fifoInValid;
  logic                 fifoInReady;
  dacr_pkg::dacr_word_t fifoInData;
  logic                 fifoOutValid;
  dacr_pkg::dacr_word_t fifoOutData;

  assign startFall = startPrev_r && !conversion_start_n;
  assign startRise = !startPrev_r && conversion_start_n;
  // Reads are framed by the strobe while select is held low
  assign readStart = readPrev_r && !readN && !chipSelectN;
  assign readEnd   = !readPrev_r && readN && !chipSelectN;

  assign convDone  = (state_r == dacr_pkg::ST_CONVERT) &&
                     (cnt_r == dacr_pkg::CONV_LAST);
  assign wakeDone  = (state_r == dacr_pkg::ST_WAKE) &&
                     (cnt_r == (internalReference ? WAKE_INT_LAST :
                                dacr_pkg::WAKE_EXT_LAST));
  assign beginHold = ((state_r == dacr_pkg::ST_IDLE) && startFall) ||
                     (wakeDone && !conversion_start_n);

  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r + 18'h00001;
    mode_nxt   = mode_r;
    sample_nxt = sample_r;
    latch_nxt  = latch_r;
    case (state_r)
      dacr_pkg::ST_IDLE:
      begin
        cnt_nxt = dacr_pkg::CNT_RESET;
        if (startFall)
          state_nxt = dacr_pkg::ST_CONVERT;
      end
      dacr_pkg::ST_CONVERT:
      begin
        if (convDone)
        begin
          cnt_nxt   = dacr_pkg::CNT_RESET;
          latch_nxt = sample_r;
          // Start level at the end of conversion picks the mode
          mode_nxt  = conversion_start_n ? dacr_pkg::MODE_CONTINUOUS
                                         : dacr_pkg::MODE_SLEEP;
          state_nxt = conversion_start_n ? dacr_pkg::ST_IDLE
                                         : dacr_pkg::ST_SLEEP;
        end
      end
      dacr_pkg::ST_SLEEP:
      begin
        cnt_nxt = dacr_pkg::CNT_RESET;
        if (startRise)
          state_nxt = dacr_pkg::ST_WAKE;
      end
      dacr_pkg::ST_WAKE:
      begin
        // Falls during wake-up are ignored; the level decides at the end
        if (wakeDone)
        begin
          cnt_nxt   = dacr_pkg::CNT_RESET;
          state_nxt = conversion_start_n ? dacr_pkg::ST_IDLE
                                         : dacr_pkg::ST_CONVERT;
        end
      end
      default:
      begin
        cnt_nxt   = dacr_pkg::CNT_RESET;
        state_nxt = dacr_pkg::ST_IDLE;
      end
    endcase
    if (beginHold)
      sample_nxt = pair_select ? pairB : pairA;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= dacr_pkg::ST_IDLE;
      cnt_r       <= dacr_pkg::CNT_RESET;
      mode_r      <= dacr_pkg::MODE_CONTINUOUS;
      startPrev_r <= 1'b1;
      readPrev_r  <= 1'b1;
      sample_r    <= '0;
      latch_r     <= '0;
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      mode_r      <= mode_nxt;
      startPrev_r <= conversion_start_n;
      readPrev_r  <= readN;
      sample_r    <= sample_nxt;
      latch_r     <= latch_nxt;
    end
  end

  // Loader refills the FIFO from the latch after each conversion
  assign fifoClear   = convDone;
  assign fifoInValid = (loadLeft_r != dacr_pkg::LOAD_NONE);
  assign fifoInData  = (loadLeft_r == dacr_pkg::LOAD_TWO) ?
                       latch_r.inputOne : latch_r.inputTwo;

  always_comb
  begin
    loadLeft_nxt = loadLeft_r;
    if (convDone)
      loadLeft_nxt = dacr_pkg::LOAD_TWO;
    else if (fifoInValid && fifoInReady)
      loadLeft_nxt = loadLeft_r - 2'h1;
  end

  // Answer one cycle after the strobe falls, far inside the read window;
  // an over-read repeats the second result rather than stale data
  always_comb
  begin
    dataOut_nxt = dataOut_r;
    if (readStart)
      dataOut_nxt = fifoOutValid ? fifoOutData
                                 : latch_r.inputTwo;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      loadLeft_r <= dacr_pkg::LOAD_NONE;
      dataOut_r  <= '0;
    end
    else
    begin
      loadLeft_r <= loadLeft_nxt;
      dataOut_r  <= dataOut_nxt;
    end
  end

  dacr_fifo
  #(
    .WIDTH (dacr_pkg::RESULT_WIDTH),
    .DEPTH (dacr_pkg::FIFO_DEPTH)
  )
  resultFifo
  (
    .clock    (clock),
    .resetn   (resetn),
    .clear    (fifoClear),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (readEnd),
    .outData  (fifoOutData)
  );

  assign dataOut    = dataOut_r;
  assign dataOe     = !chipSelectN && !readN;
  assign busy       = (state_r == dacr_pkg::ST_CONVERT);
  assign holdActive = (state_r == dacr_pkg::ST_CONVERT);
  assign asleep     = (state_r == dacr_pkg::ST_SLEEP);
  assign sleepMode  = mode_r;

endmodule

// ---- dv/dacr_host.sv ----
// Host model: start, pair select and read strobes
`timescale 1ns/1ps
module dacr_host
(
  // Clock
  input  wire logic                 clock,
  // Host drive
  output      logic                 startN,
  output      logic                 pairSel,
  output      logic                 csN,
  output      logic                 rdN,
  // Read data
  input  wire dacr_pkg::dacr_word_t dataOut
);
  initial
  begin
    startN = 1'b1;
    pairSel = 1'b0;
    csN = 1'b1;
    rdN = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // Long lead covers select setup and settling
  task automatic fall(input logic sel);
    pairSel = sel;
    step(25);
    startN = 1'b0;
  endtask
  task automatic rise();
    startN = 1'b1;
  endtask
  // Select stays low over the strobe's end so the pop is taken
  task automatic readWord(output dacr_pkg::dacr_word_t w);
    csN = 1'b0;
    rdN = 1'b0;
    step(2);
    w = dataOut;
    rdN = 1'b1;
    step(1);
    csN = 1'b1;
    step(1);
  endtask
endmodule

// ---- dv/dacr_readout_bench.sv ----
// Self-checking bench of the converter readout
`timescale 1ns/1ps
module dacr_readout_bench;
  localparam int WAKE_N = 50;
  logic                 clock = 1'b0;
  logic                 resetn;
  logic                 intRef;
  logic                 startN;
  logic                 pairSel;
  logic                 csN;
  logic                 rdN;
  logic                 dataOe;
  logic                 busy;
  logic                 holdActive;
  logic                 asleep;
  logic                 sleepMode;
  dacr_pkg::dacr_word_t dataOut;
  dacr_pkg::dacr_pair_t pairA;
  dacr_pkg::dacr_pair_t pairB;
  int                   err_count = 0;
  int                   checks = 0;
  int                   cycles = 0;
  always #10 clock = ~clock;
  dacr_readout #(.WakeIntCycles(WAKE_N)) u_dacr_readout (
    .clock(clock), .resetn(resetn), .conversion_start_n(startN),
    .pair_select(pairSel), .internalReference(intRef),
    .pairA(pairA), .pairB(pairB), .chipSelectN(csN), .readN(rdN),
    .dataOut(dataOut), .dataOe(dataOe), .busy(busy),
    .holdActive(holdActive), .asleep(asleep), .sleepMode(sleepMode));
  dacr_host u_dacr_host (.clock(clock), .startN(startN),
    .pairSel(pairSel), .csN(csN), .rdN(rdN), .dataOut(dataOut));
  task automatic check(input logic ok, input string msg);
    checks++;
    if (!ok)
    begin
      err_count++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Bounded waits so a stuck flag ends as a mismatch
  task automatic waitBusy(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl && n < 400)
    begin
      u_dacr_host.step(1);
      n++;
    end
  endtask
  // Front-end values flip after hold to prove sampling at hold
  task automatic conv(input logic sel, input logic low);
    int n;
    dacr_pkg::dacr_word_t w;
    dacr_pkg::dacr_pair_t e;
    e = sel ? pairB : pairA;
    u_dacr_host.fall(sel);
    u_dacr_host.step(2);
    check(busy === 1'b1 && holdActive === 1'b1, "no hold");
    pairA = ~pairA;
    pairB = ~pairB;
    if (!low)
      u_dacr_host.rise();
    waitBusy(1'b0, n);
    // Count starts one cycle after busy rose
    check(n == dacr_pkg::CONV_CYCLES - 1, "conversion time");
    u_dacr_host.step(3);
    check(asleep === low && sleepMode === low, "mode");
    u_dacr_host.readWord(w);
    check(w === e.inputOne, "first word");
    u_dacr_host.readWord(w);
    check(w === e.inputTwo, "second word");
    u_dacr_host.readWord(w);
    check(w === e.inputTwo, "over-read");
  endtask
  task automatic wakeExt();
    intRef = 1'b0;
    u_dacr_host.rise();
    u_dacr_host.step(130);
    check(asleep === 1'b0 && busy === 1'b0, "ext wake");
  endtask
  task automatic wakeInt();
    int n;
    intRef = 1'b1;
    u_dacr_host.rise();
    u_dacr_host.fall(1'b0);
    waitBusy(1'b1, n);
    n += 25;
    check(n >= WAKE_N + 1 && n <= WAKE_N + 3, "int wake");
    waitBusy(1'b0, n);
    check(n == 180, "wake conversion");
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    resetn = 1'b0;
    intRef = 1'b0;
    pairA = 24'h123456;
    pairB = 24'habcdef;
    repeat (10) @(posedge clock);
    #2;
    resetn = 1'b1;
    u_dacr_host.step(2);
    conv(1'b0, 1'b0);
    conv(1'b1, 1'b0);
    conv(1'b0, 1'b1);
    wakeExt();
    conv(1'b1, 1'b1);
    wakeInt();
    finish_test();
  end
endmodule
bind dacr_readout dacr_readout_sva #(.WakeIntCycles(WakeIntCycles))
  u_dacr_readout_sva (.clock(clock), .resetn(resetn),
  .conversion_start_n(conversion_start_n), .chipSelectN(chipSelectN),
  .readN(readN), .dataOut(dataOut), .dataOe(dataOe), .busy(busy),
  .holdActive(holdActive), .asleep(asleep), .sleepMode(sleepMode));

// ---- dv/dacr_readout_sva.sv ----
// Checker on the readout ports
`timescale 1ns/1ps
module dacr_readout_sva
#(
  parameter int unsigned WakeIntCycles = 50
)
(
  input wire logic                 clock,
  input wire logic                 resetn,
  input wire logic                 conversion_start_n,
  input wire logic                 chipSelectN,
  input wire logic                 readN,
  input wire dacr_pkg::dacr_word_t dataOut,
  input wire logic                 dataOe,
  input wire logic                 busy,
  input wire logic                 holdActive,
  input wire logic                 asleep,
  input wire logic                 sleepMode
);
  logic [7:0] busyCnt_r;
  logic [7:0] busyCnt_nxt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  always_comb
  begin
    busyCnt_nxt = busy ? busyCnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      busyCnt_r <= 8'h00;
    else
      busyCnt_r <= busyCnt_nxt;
  end
  busy_cause_a: assert property ($rose(busy) |->
    !$past(conversion_start_n)) else $error("busy without start");
  busy_len_a: assert property ($fell(busy) |->
    busyCnt_r == 8'hb4) else $error("busy length wrong");
  hold_track_a: assert property (holdActive == busy)
    else $error("hold differs from busy");
  read_oe_a: assert property (dataOe == (!chipSelectN && !readN))
    else $error("output enable wrong");
  mode_pick_a: assert property ($fell(busy) |->
    sleepMode == !$past(conversion_start_n)) else $error("mode wrong");
  sleep_entry_a: assert property ($fell(busy) |->
    asleep == !$past(conversion_start_n)) else $error("sleep wrong");
  wake_rise_a: assert property ($fell(asleep) |->
    $past(conversion_start_n) ##0 !busy [*8])
    else $error("wake wrong");
  data_hold_a: assert property ($changed(dataOut) |->
    !$past(readN) && !$past(chipSelectN)) else $error("data moved");
  sleep_quiet_a: assert property (asleep |-> !busy)
    else $error("busy while asleep");
  cover property ($rose(asleep));
  cover property ($fell(asleep));
  cover property ($changed(dataOut));
endmodule
